/* design/sbit_defs.vh */
// Constants for the sixteen-bit interval timer: register map and fields.
// Assumes inclusion by bare name from the timer design files.
`ifndef SBIT_DEFS_VH
`define SBIT_DEFS_VH

// ****************************************************************
// Register byte addresses
// ****************************************************************
`define SBIT_ADDR_CONTROL 4'h0
`define SBIT_ADDR_PERIOD 4'h4
`define SBIT_ADDR_COUNT 4'h8
`define SBIT_ADDR_STATUS 4'hC

// ****************************************************************
// Control field positions
// ****************************************************************
`define SBIT_RUN_BIT 15
`define SBIT_IDLE_BIT 13
`define SBIT_ESRC_HI 9
`define SBIT_ESRC_LO 8
`define SBIT_GATE_BIT 6
`define SBIT_PRE_HI 5
`define SBIT_PRE_LO 4
`define SBIT_SYNC_BIT 2
`define SBIT_SRC_BIT 1
`define SBIT_CTRL_MASK 16'hA376

// ****************************************************************
// Encodings and reset values
// ****************************************************************
`define SBIT_ESRC_SECONDARY_OSCILLATOR 2'h0
`define SBIT_ESRC_PIN 2'h1
`define SBIT_ESRC_LOW_POWER_RC_OSCILLATOR 2'h2
`define SBIT_PRE_1 2'h0
`define SBIT_PRE_8 2'h1
`define SBIT_PRE_64 2'h2
`define SBIT_PRE_256 2'h3
`define SBIT_DIV_8 8'h07
`define SBIT_DIV_64 8'h3F
`define SBIT_DIV_256 8'hFF
`define SBIT_CTRL_RST 16'h0000
`define SBIT_PERIOD_RST 16'hFFFF
`define SBIT_RESP_OKAY 2'h0
`define SBIT_RESP_SLVERR 2'h2

`endif

/* design/sbit_tick_gen.v */
// Tick source selection, synchronisation and prescaler for the timer.
// Assumes external sources are slow compared with clk_sys.
`timescale 1ns/1ps
`default_nettype none
`include "sbit_defs.vh"

module sbit_tick_gen (
   input wire clk_sys,
   input wire resetn,
   input wire enable,
   input wire src_ext,
   input wire [1:0] esrc,
   input wire sync_on,
   input wire [1:0] pre_sel,
   input wire gate_on,
   input wire gate_in,
   input wire int_tick,
   input wire ext_pin,
   input wire low_power_rc_oscillator_clk,
   input wire secondary_oscillator_clk,
   output reg tick_ff
);

   // ****************************************************************
   // Source selection
   // ****************************************************************
   reg raw_src;
   always @* begin
      case (esrc)
         `SBIT_ESRC_LOW_POWER_RC_OSCILLATOR: raw_src = low_power_rc_oscillator_clk;
         `SBIT_ESRC_PIN: raw_src = ext_pin;
         `SBIT_ESRC_SECONDARY_OSCILLATOR: raw_src = secondary_oscillator_clk;
         default: raw_src = 1'b0;
      endcase
   end

   // Both paths share one clock, so the unsynchronised path only skips the
   // two-stage delay; a true async counter needs its own clock domain.
   reg s1_ff, s2_ff, s3_ff, r1_ff;
   always @(posedge clk_sys) begin
      if (!resetn) begin
         s1_ff <= 1'b0;
         s2_ff <= 1'b0;
         s3_ff <= 1'b0;
         r1_ff <= 1'b0;
      end else begin
         s1_ff <= raw_src;
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         r1_ff <= raw_src;
      end
   end

   wire ext_edge = sync_on ? (s2_ff & ~s3_ff) : (raw_src & ~r1_ff);
   wire gate_ok = ~gate_on | gate_in;
   wire src_tick = src_ext ? ext_edge : (int_tick & gate_ok);

   // ****************************************************************
   // Prescaler
   // ****************************************************************
   reg [7:0] pre_ff;
   reg [7:0] pre_top;
   always @* begin
      case (pre_sel)
         `SBIT_PRE_8: pre_top = `SBIT_DIV_8;
         `SBIT_PRE_64: pre_top = `SBIT_DIV_64;
         `SBIT_PRE_256: pre_top = `SBIT_DIV_256;
         default: pre_top = 8'h00;
      endcase
   end

   always @(posedge clk_sys) begin
      if (!resetn || !enable) begin
         pre_ff <= 8'h00;
         tick_ff <= 1'b0;
      end else begin
         tick_ff <= 1'b0;
         if (src_tick) begin
            if (pre_ff >= pre_top) begin
               pre_ff <= 8'h00;
               tick_ff <= 1'b1;
            end else begin
               pre_ff <= pre_ff + 8'h01;
            end
         end
      end
   end

endmodule // sbit_tick_gen
`default_nettype wire

/* design/sbit_timer.v */
// Sixteen-bit interval timer with AXI4-Lite register access.
// Assumes one clock, synchronous active-low reset, inputs synchronous.
//
// Behaviour
// - Sixteen-bit counter runs as timer, synchronous counter or asynchronous counter.
// - Control bit 15 set starts the counter, clear stops it.
// - Control bit 13 set halts counting during idle, clear keeps running.
// - Control bit 1 picks internal half-rate clock or the extended source.
// - Extended source 10 low-power RC, 01 tick pin, 00 secondary oscillator.
// - Extended source field matters only while bit 1 is set.
// - Bit 6 gates internal counting by the gate input; ignored for external.
// - Prescale 11 divides 256, 10 by 64, 01 by 8, 00 none.
// - Bit 2 selects synchronised external clock; ignored for internal clock.
// - Event pulse on period match outside gated mode, or gate falling edge in gated mode.
// - Counter keeps working in idle or sleep, per idle halt and source.
// - Unimplemented control bits read zero; implemented bits reset to zero.
//
// The AXI4-Lite slave port and the register addresses were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "sbit_defs.vh"

module sbit_timer (
   input wire clk_sys,
   input wire resetn,
   input wire [3:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [3:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire cpu_idle,
   input wire cpu_sleep,
   input wire external_tick_pin,
   input wire low_power_rc_oscillator,
   input wire secondary_oscillator,
   input wire gate_in,
   output reg timer_event_ff
);

   // ****************************************************************
   // Registers
   // ****************************************************************
   reg [15:0] ctrl_ff;
   reg [15:0] period_ff;
   reg [15:0] count_ff;
   reg match_ff;
   reg half_ff;
   reg gate_d_ff;

   // Bus holding registers.
   reg [3:0] aw_addr_ff;
   reg [31:0] w_data_ff;
   reg [3:0] w_strb_ff;
   reg aw_have_ff;
   reg w_have_ff;
   wire tick;

   wire run_control = ctrl_ff[`SBIT_RUN_BIT];
   wire idle_halt = ctrl_ff[`SBIT_IDLE_BIT];
   wire [1:0] extended_source_select = ctrl_ff[`SBIT_ESRC_HI:`SBIT_ESRC_LO];
   wire gate_accumulate = ctrl_ff[`SBIT_GATE_BIT];
   wire [1:0] prescale_select = ctrl_ff[`SBIT_PRE_HI:`SBIT_PRE_LO];
   wire external_sync_select = ctrl_ff[`SBIT_SYNC_BIT];
   wire source_select = ctrl_ff[`SBIT_SRC_BIT];

   // The internal clock stops in sleep; external sources keep counting.
   wire idle_stop = cpu_idle & idle_halt;
   wire sleep_stop = cpu_sleep & ~source_select;
   wire halted = idle_stop | sleep_stop;
   wire enable = run_control & ~halted;
   wire gated = gate_accumulate & ~source_select;

   function [15:0] merge16;
      input [15:0] old;
      input [31:0] data;
      input [3:0] strb;
      begin
         merge16 = {strb[1] ? data[15:8] : old[15:8],
                    strb[0] ? data[7:0] : old[7:0]};
      end
   endfunction

   function mapped;
      input [3:0] addr;
      begin
         case (addr)
            `SBIT_ADDR_CONTROL: mapped = 1'b1;
            `SBIT_ADDR_PERIOD: mapped = 1'b1;
            `SBIT_ADDR_COUNT: mapped = 1'b1;
            `SBIT_ADDR_STATUS: mapped = 1'b1;
            default: mapped = 1'b0;
         endcase
      end
   endfunction

   // ****************************************************************
   // Tick generation
   // ****************************************************************
   always @(posedge clk_sys) begin
      if (!resetn) begin
         half_ff <= 1'b0;
      end else begin
         half_ff <= ~half_ff;
      end
   end

   // The half-rate strobe stands in for the internal instruction clock.
   sbit_tick_gen u_tick (
      .clk_sys(clk_sys),
      .resetn(resetn),
      .enable(enable),
      .src_ext(source_select),
      .esrc(extended_source_select),
      .sync_on(external_sync_select),
      .pre_sel(prescale_select),
      .gate_on(gated),
      .gate_in(gate_in),
      .int_tick(half_ff),
      .ext_pin(external_tick_pin),
      .low_power_rc_oscillator_clk(low_power_rc_oscillator),
      .secondary_oscillator_clk(secondary_oscillator),
      .tick_ff(tick)
   );

   // ****************************************************************
   // Bus write path
   // ****************************************************************
   wire aw_take = s_axi_awvalid & s_axi_awready;
   wire w_take = s_axi_wvalid & s_axi_wready;
   wire wr_go = aw_have_ff & w_have_ff & ~s_axi_bvalid;

   // A write lands one edge after both halves are held, so bvalid rises
   // two edges after a joint take; one spare cycle buys a simple decode.
   // Unmapped words get a SLVERR answer and leave every register alone.
   wire sel_ctrl = (aw_addr_ff == `SBIT_ADDR_CONTROL);
   wire sel_period = (aw_addr_ff == `SBIT_ADDR_PERIOD);
   wire sel_count = (aw_addr_ff == `SBIT_ADDR_COUNT);
   wire cnt_wr = wr_go & sel_count;

   always @(posedge clk_sys) begin
      if (!resetn) begin
         s_axi_awready <= 1'b1;
         s_axi_wready <= 1'b1;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `SBIT_RESP_OKAY;
         aw_have_ff <= 1'b0;
         w_have_ff <= 1'b0;
         aw_addr_ff <= 4'h0;
         w_data_ff <= 32'h0000_0000;
         w_strb_ff <= 4'h0;
         ctrl_ff <= `SBIT_CTRL_RST;
         period_ff <= `SBIT_PERIOD_RST;
      end else begin
         if (aw_take) begin
            aw_addr_ff <= s_axi_awaddr;
            aw_have_ff <= 1'b1;
            s_axi_awready <= 1'b0;
         end
         if (w_take) begin
            w_data_ff <= s_axi_wdata;
            w_strb_ff <= s_axi_wstrb;
            w_have_ff <= 1'b1;
            s_axi_wready <= 1'b0;
         end
         if (wr_go) begin
            aw_have_ff <= 1'b0;
            w_have_ff <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= mapped(aw_addr_ff) ? `SBIT_RESP_OKAY :
                           `SBIT_RESP_SLVERR;
            if (sel_ctrl) begin
               ctrl_ff <= merge16(ctrl_ff, w_data_ff, w_strb_ff) &
                          `SBIT_CTRL_MASK;
            end
            if (sel_period) begin
               period_ff <= merge16(period_ff, w_data_ff, w_strb_ff);
            end
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
         end
      end
   end

   // ****************************************************************
   // Counter and event
   // ****************************************************************
   // The gate is compared with its own copy from the cycle before, so a
   // fall is seen as old high and new low in the cycle the pin falls; the event register follows one edge later.
   wire gate_fall = gated & gate_d_ff & ~gate_in & run_control;
   reg [15:0] nxt_count;
   reg nxt_match;
   reg nxt_event;
   reg [15:0] count_inc;

   always @* begin
      count_inc = count_ff + 16'h0001;
      nxt_count = count_ff;
      nxt_match = match_ff;
      nxt_event = gate_fall;
      if (cnt_wr) begin
         nxt_count = merge16(count_ff, w_data_ff, w_strb_ff);
         nxt_match = 1'b0;
      end else if (tick) begin
         if (match_ff) begin
            nxt_count = 16'h0000;
            nxt_match = 1'b0;
         end else begin
            nxt_count = count_inc;
            if (count_inc == period_ff) begin
               nxt_match = 1'b1;
               // A gate fall in the same cycle must not be lost.
               nxt_event = gate_fall | ~gated;
            end
         end
      end
   end

   always @(posedge clk_sys) begin
      if (!resetn) begin
         count_ff <= 16'h0000;
         match_ff <= 1'b0;
         gate_d_ff <= 1'b0;
         timer_event_ff <= 1'b0;
      end else begin
         gate_d_ff <= gate_in;
         count_ff <= nxt_count;
         match_ff <= nxt_match;
         timer_event_ff <= nxt_event;
      end
   end

   // ****************************************************************
   // Bus read path
   // ****************************************************************
   // Status bit 0 shows counting enabled, bit 1 a pending match.
   wire [15:0] status_word = {14'h0000, match_ff, enable};

   function [31:0] rd_word;
      input [3:0] addr;
      input [15:0] ctrl;
      input [15:0] period;
      input [15:0] count;
      input [15:0] status;
      begin
         case (addr)
            `SBIT_ADDR_CONTROL: rd_word = {16'h0000, ctrl};
            `SBIT_ADDR_PERIOD: rd_word = {16'h0000, period};
            `SBIT_ADDR_COUNT: rd_word = {16'h0000, count};
            `SBIT_ADDR_STATUS: rd_word = {16'h0000, status};
            default: rd_word = 32'h0000_0000;
         endcase
      end
   endfunction

   always @(posedge clk_sys) begin
      if (!resetn) begin
         s_axi_arready <= 1'b1;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h0000_0000;
         s_axi_rresp <= `SBIT_RESP_OKAY;
      end else begin
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= mapped(s_axi_araddr) ? `SBIT_RESP_OKAY :
                           `SBIT_RESP_SLVERR;
            s_axi_rdata <= rd_word(s_axi_araddr, ctrl_ff, period_ff,
                                   count_ff, status_word);
         end
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
         end
      end
   end

endmodule // sbit_timer
`default_nettype wire

/* verification/sbit_src_model.sv */
// Free-running external tick sources and the gate driver for the timer.
// Assumes clk_sys is the timer clock; levels change just after its edge.
`timescale 1ns/1ps
`default_nettype none
module sbit_src_model #(parameter int H_PIN = 3, H_LOW_POWER_RC_OSCILLATOR = 4, H_SECONDARY_OSCILLATOR = 5) (
   input wire logic clk_sys,
   input wire logic gate_cmd,
   output wire logic external_tick_pin,
   output wire logic low_power_rc_oscillator,
   output wire logic secondary_oscillator,
   output wire logic gate_in
);
   // ********
   // Sources
   // ********
   int cyc = 0;
   logic gate_ff = 1'h0;
   // Each level lasts at least two clocks, so no edge is lost.
   assign external_tick_pin = ((cyc / H_PIN) % 2) == 1;
   assign low_power_rc_oscillator = ((cyc / H_LOW_POWER_RC_OSCILLATOR) % 2) == 1;
   assign secondary_oscillator = ((cyc / H_SECONDARY_OSCILLATOR) % 2) == 1;
   assign gate_in = gate_ff;
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      gate_ff <= gate_cmd;
   end
endmodule // sbit_src_model
`default_nettype wire

/* verification/sbit_timer_props.sv */
// Checker for the interval timer bus handshakes and event pulse.
// Assumes it is bound to sbit_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sbit_timer_props (
   input wire logic clk_sys,
   input wire logic resetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic timer_event_ff
);
   // ********
   // Properties
   // ********
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!resetn);
   AST_RST_IDLE: assert property ($rose(resetn) |-> s_axi_awready
      && s_axi_arready && !s_axi_bvalid && !timer_event_ff)
      else $error("bad state after reset");
   AST_W_ANSWER: assert property (s_axi_awvalid && s_axi_awready
      && s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write not answered");
   AST_AW_TAKEN: assert property (s_axi_awvalid && s_axi_awready
      |=> !s_axi_awready) else $error("address ready stayed high");
   AST_B_BLOCKS: assert property (s_axi_bvalid |-> !s_axi_awready
      && !s_axi_wready) else $error("ready during response");
   AST_B_DONE: assert property (s_axi_bvalid && s_axi_bready
      |=> !s_axi_bvalid) else $error("response stuck");
   AST_R_ANSWER: assert property (s_axi_arvalid && s_axi_arready
      |=> s_axi_rvalid && !s_axi_arready) else $error("read not answered");
   AST_R_DONE: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid) else $error("read data stuck");
   AST_EVT_PULSE: assert property (timer_event_ff
      |=> !timer_event_ff) else $error("event wider than one cycle");
   cover property (timer_event_ff);
   cover property (s_axi_bvalid && s_axi_bready);
   cover property (s_axi_rvalid && s_axi_rready);
endmodule // sbit_timer_props
bind sbit_timer sbit_timer_props i_props (.clk_sys, .resetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
   .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
   .s_axi_rvalid, .s_axi_rready, .timer_event_ff);
`default_nettype wire

/* verification/sbit_timer_tb.sv */
// Self-checking bench for the interval timer over its register bus.
// Assumes sbit_timer, sbit_src_model and the bound checker are compiled.
`timescale 1ns/1ps
`default_nettype none
module sbit_timer_tb;
   logic clk_sys = 1'h0;
   logic resetn = 1'h0;
   logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0;
   logic [3:0] s_axi_wstrb = 4'h3;
   logic [31:0] s_axi_wdata = 32'h0;
   logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
   logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
   logic cpu_idle = 1'h0, gate_cmd = 1'h0, cpu_sleep = 1'h0;
   wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
   wire logic s_axi_rvalid, timer_event_ff, gate_in;
   wire logic external_tick_pin, low_power_rc_oscillator;
   wire logic secondary_oscillator;
   wire logic [1:0] s_axi_bresp, s_axi_rresp;
   wire logic [31:0] s_axi_rdata;
   int n_fail = 0;
   int compares = 0;
   logic [31:0] rv, a, n;
   logic [1:0] rr;
   // Gaps between events with period 1: two ticks of 2*div clocks.
   logic [31:0] pre_gap [4] = '{32'h4, 32'h20, 32'h100, 32'h400};
   logic [31:0] ext_gap [3] = '{32'h14, 32'hC, 32'h10};
   sbit_timer i_dut (.clk_sys, .resetn, .s_axi_awaddr, .s_axi_awvalid,
      .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
      .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
      .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
      .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .cpu_idle,
      .cpu_sleep, .external_tick_pin, .low_power_rc_oscillator,
      .secondary_oscillator, .gate_in, .timer_event_ff);
   sbit_src_model i_src (.clk_sys, .gate_cmd, .external_tick_pin,
      .low_power_rc_oscillator, .secondary_oscillator, .gate_in);
   initial forever #10 clk_sys = ~clk_sys;
   // ********
   // Bus and check tasks
   // ********
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_fail++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [3:0] ad, input logic [15:0] d);
      @(posedge clk_sys);
      s_axi_awaddr <= ad;
      s_axi_wdata <= {16'h0, d};
      s_axi_awvalid <= 1'h1;
      s_axi_wvalid <= 1'h1;
      s_axi_bready <= 1'h1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_awready) s_axi_awvalid <= 1'h0;
         if (s_axi_wready) s_axi_wvalid <= 1'h0;
         if (s_axi_bvalid) break;
      end
      rr = s_axi_bresp;
      s_axi_bready <= 1'h0;
   endtask
   task automatic rd(input logic [3:0] ad);
      @(posedge clk_sys);
      s_axi_araddr <= ad;
      s_axi_arvalid <= 1'h1;
      s_axi_rready <= 1'h1;
      forever begin
         @(posedge clk_sys);
         if (s_axi_arready) s_axi_arvalid <= 1'h0;
         if (s_axi_rvalid) break;
      end
      rv = s_axi_rdata;
      rr = s_axi_rresp;
      s_axi_rready <= 1'h0;
   endtask
   // The first event after a change may be partial, so time the next.
   task automatic gap;
      n = 0;
      repeat (3000) begin
         @(posedge clk_sys);
         if (timer_event_ff) break;
      end
      repeat (3000) begin
         @(posedge clk_sys);
         n = n + 1;
         if (timer_event_ff) break;
      end
   endtask
   task automatic hold;
      rd(4'h8);
      a = rv;
      repeat (21) @(posedge clk_sys);
      rd(4'h8);
      chk(rv, a);
   endtask
   task automatic close_out;
      $display("Compares %0d, mismatches %0d", compares, n_fail);
      if (n_fail == 0 && compares > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // ********
   // Scenarios
   // ********
   task automatic t_regs;
      rd(4'h0);
      chk(rv, 32'h0);
      wr(4'h0, 16'hFFFF);
      chk({30'h0, rr}, 32'h0);
      rd(4'h0);
      chk(rv, 32'hA376);
      rd(4'h2);
      chk({30'h0, rr}, 32'h2);
      wr(4'h2, 16'h1234);
      chk({30'h0, rr}, 32'h2);
      rd(4'h0);
      chk(rv, 32'hA376);
      wr(4'h0, 16'h0);
      wr(4'h8, 16'h0);
      wr(4'h4, 16'h1);
   endtask
   task automatic t_int;
      for (int p = 0; p < 4; p++) begin
         wr(4'h0, 16'h8000 | 16'(p * 16));
         gap;
         chk(n, pre_gap[p]);
      end
      wr(4'h0, 16'h8304);
      gap;
      chk(n, 32'h4);
      rd(4'hC);
      chk(rv & 32'h1, 32'h1);
   endtask
   task automatic t_hold;
      wr(4'h4, 16'hFF);
      wr(4'h0, 16'hA000);
      cpu_idle <= 1'h1;
      hold;
      wr(4'h8, 16'h0);
      wr(4'h4, 16'h1);
      wr(4'h0, 16'h8000);
      gap;
      chk(n, 32'h4);
      cpu_idle <= 1'h0;
      wr(4'h4, 16'hFF);
      wr(4'h0, 16'h0);
      hold;
      cpu_sleep <= 1'h1;
      wr(4'h0, 16'h8000);
      hold;
      rd(4'hC);
      chk(rv & 32'h1, 32'h0);
      wr(4'h8, 16'h0);
      wr(4'h4, 16'h1);
      wr(4'h0, 16'h8102);
      gap;
      chk(n, 32'hC);
      cpu_sleep <= 1'h0;
   endtask
   task automatic t_ext;
      for (int e = 0; e < 3; e++) begin
         for (int s = 0; s < 2; s++) begin
            wr(4'h0, 16'h8042 | 16'(e * 256) | 16'(s * 4));
            gap;
            chk(n, ext_gap[e]);
         end
      end
   endtask
   task automatic t_gate;
      wr(4'h0, 16'h8040);
      gate_cmd <= 1'h1;
      n = 0;
      repeat (20) begin
         @(posedge clk_sys);
         if (timer_event_ff) n = n + 1;
      end
      chk(n, 32'h0);
      gate_cmd <= 1'h0;
      repeat (8) begin
         @(posedge clk_sys);
         if (timer_event_ff) n = n + 1;
      end
      chk(n, 32'h1);
   endtask
   initial begin
      repeat (12) @(posedge clk_sys);
      resetn <= 1'h1;
      t_regs;
      t_int;
      t_hold;
      t_ext;
      t_gate;
      close_out;
   end
   // A hang is cut off well past the expected run of about 3000 clocks.
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_fail++;
      close_out;
   end
endmodule // sbit_timer_tb
`default_nettype wire
